// File: adpw_decode.sv
// Purpose: Prioritised address decode, chip selects and program page window
// Assumes: Bus inputs synchronous; one bus cycle per clock
// Notes: Outputs registered, so they reflect the address of the prior edge
`timescale 1ns/10ps
`include "adpw_defs.svh"
module adpw_decode
   import adpw_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Core bus
   input wire adpw_bus_t bus,
   // Far call and return page load
   input wire logic seq_page_load,
   input wire logic [5:0] seq_page_value,
   // Mode and mapping control
   input wire adpw_mode_t mode,
   input wire adpw_map_t map,
   input wire logic port_e_emulation_enable,
   input wire logic port_k_emulation_enable,
   input wire logic prog_low_hide,
   input wire logic [1:0] rom_alloc_switches,
   input wire logic [1:0] paging_partition_switches,
   // Decoded results
   output adpw_sel_t sel_reg,
   output logic emulation_chip_select_n,
   output logic external_chip_select_n,
   output logic [5:0] extended_upper_address,
   output logic [5:0] program_page_register,
   output logic page_internal_reg
);
   logic [15:0] a;
   logic [15:0] reg_ofs;
   logic expanded;
   logic emul;
   logic in_regs;
   logic removed;
   logic in_win;
   logic page_int;
   logic rom_claim;
   logic ecs_hit;
   adpw_sel_t sel_next;

   assign a = bus.addr;
   assign reg_ofs = a - map.reg_base;
   assign emul = (mode == ADPW_MODE_EMUL_EXP);
   assign expanded = (mode == ADPW_MODE_NORMAL_EXP) || emul
      || (mode == ADPW_MODE_TEST);
   assign in_regs = (a >= map.reg_base) && (reg_ofs < `ADPW_REG_SIZE);
   assign in_win = (a >= `ADPW_WIN_LO) && (a <= `ADPW_WIN_HI);

   adpw_page_class u_class
   (
      .page_index_bits(program_page_register),
      .paging_partition_switches(paging_partition_switches),
      .internal(page_int)
   );

   // Register slots removed from the register map; expanded modes hand them to the ext bus
   always_comb
   begin
      removed = 1'b0;
      if (expanded && (reg_ofs == `ADPW_PORTA_OFS
         || reg_ofs == `ADPW_PORTB_OFS || reg_ofs == `ADPW_DDRA_OFS
         || reg_ofs == `ADPW_DDRB_OFS))
         removed = 1'b1;
      if (expanded && port_e_emulation_enable
         && (reg_ofs == `ADPW_PORTE_OFS || reg_ofs == `ADPW_DDRE_OFS))
         removed = 1'b1;
      if (mode == ADPW_MODE_PERIPH && reg_ofs < `ADPW_EXP_REGS)
         removed = 1'b1;
      if (emul && port_k_emulation_enable
         && (reg_ofs == `ADPW_PORTK_OFS || reg_ofs == `ADPW_DDRK_OFS))
         removed = 1'b1;
      removed = removed && in_regs;
   end

   // Program memory claim: top block by alloc, window by page, low by enable unless hidden
   always_comb
   begin
      rom_claim = 1'b0;
      if (a >= `ADPW_WIN_LO && !in_win)
         rom_claim = (rom_alloc_switches != 2'b00);
      else if (in_win)
         rom_claim = page_int;
      else if (map.prog_low_en && !prog_low_hide)
         rom_claim = (a >= map.prog_low_base);
   end

   // One-hot priority select
   always_comb
   begin
      sel_next = '0;
      if (map.debug_en && a >= (16'hFFFF - `ADPW_DBG_SIZE + 16'h0001))
         sel_next.debug = 1'b1;
      else if (in_regs && !removed)
         sel_next.regs = 1'b1;
      else if (!in_regs && a >= map.ram_base
         && (a - map.ram_base) < map.ram_size)
         sel_next.ram = 1'b1;
      else if (!in_regs && a >= map.ee_base
         && (a - map.ee_base) < map.ee_size)
         sel_next.eeprom = 1'b1;
      else if (!in_regs && rom_claim)
         sel_next.prog = 1'b1;
      else if (expanded)
         sel_next.ext = 1'b1;
   end

   assign ecs_hit = emul && port_k_emulation_enable && sel_next.prog;

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         sel_reg <= '0;
      else
         sel_reg <= bus.valid ? sel_next : '0;
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         emulation_chip_select_n <= 1'b1;
         external_chip_select_n <= 1'b1;
      end
      else
      begin
         emulation_chip_select_n <= !(bus.valid && ecs_hit);
         // Removed slots select the ext bus in expanded modes but not this select
         external_chip_select_n <= !(bus.valid && port_k_emulation_enable
            && !ecs_hit && sel_next.ext && !removed);
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         extended_upper_address <= `ADPW_XA_TOP;
      else if (expanded && port_k_emulation_enable)
      begin
         if (in_win)
            extended_upper_address <= program_page_register;
         else if (a >= `ADPW_WIN_LO)
            extended_upper_address <= `ADPW_XA_TOP;
         else if (a[14])
            extended_upper_address <= `ADPW_XA_MID;
         else
            extended_upper_address <= `ADPW_XA_LOW;
      end
   end

   // Page register: sequence load wins over a bus write in the same cycle
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         program_page_register <= `ADPW_PAGE_RESET;
      else if (seq_page_load)
         program_page_register <= seq_page_value;
      else if (bus.valid && bus.write && in_regs
         && reg_ofs == `ADPW_PAGE_OFS)
         program_page_register <= bus.wdata[5:0];
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         page_internal_reg <= 1'b0;
      else
         page_internal_reg <= page_int;
   end

   AST_ONEHOT: assert property (@(posedge clock) disable iff (!reset_n)
      $onehot0(sel_reg)) else $error("more than one select");
   AST_REGS_OVER_RAM: assert property (@(posedge clock) disable iff (!reset_n)
      bus.valid && in_regs && !removed && !sel_next.debug |=> sel_reg.regs)
      else $error("registers lost priority");
   AST_EXP_PORTA: assert property (@(posedge clock) disable iff (!reset_n)
      bus.valid && expanded && in_regs && reg_ofs == `ADPW_PORTA_OFS
      |=> !sel_reg.regs) else $error("port A stayed internal");
   AST_PORTE: assert property (@(posedge clock) disable iff (!reset_n)
      bus.valid && expanded && port_e_emulation_enable && in_regs
      && reg_ofs == `ADPW_DDRE_OFS |=> !sel_reg.regs)
      else $error("port E stayed internal");
   AST_PERIPH: assert property (@(posedge clock) disable iff (!reset_n)
      bus.valid && mode == ADPW_MODE_PERIPH && in_regs
      && reg_ofs < `ADPW_EXP_REGS |=> !sel_reg.regs)
      else $error("expansion register stayed internal");
   AST_PORTK: assert property (@(posedge clock) disable iff (!reset_n)
      bus.valid && emul && port_k_emulation_enable && in_regs
      && reg_ofs == `ADPW_PORTK_OFS |=> !sel_reg.regs)
      else $error("port K stayed internal");
   AST_ECS_COND: assert property (@(posedge clock) disable iff (!reset_n)
      !emulation_chip_select_n |-> sel_reg.prog && $past(emul))
      else $error("emulation select outside program space");
   AST_XCS_EXCL: assert property (@(posedge clock) disable iff (!reset_n)
      !external_chip_select_n |-> emulation_chip_select_n && sel_reg.ext)
      else $error("external select misplaced");
   AST_XCS_REMOVED: assert property (@(posedge clock) disable iff (!reset_n)
      removed |=> external_chip_select_n)
      else $error("external select on removed slot");
   AST_PAGE_WRITE: assert property (@(posedge clock) disable iff (!reset_n)
      bus.valid && bus.write && in_regs && reg_ofs == `ADPW_PAGE_OFS
      && !seq_page_load |=> program_page_register == $past(bus.wdata[5:0]))
      else $error("page write not applied");
   AST_SEQ_LOAD: assert property (@(posedge clock) disable iff (!reset_n)
      seq_page_load |=> program_page_register == $past(seq_page_value))
      else $error("sequence page load lost");
   AST_XA_WIN: assert property (@(posedge clock) disable iff (!reset_n)
      expanded && port_k_emulation_enable && in_win
      |=> extended_upper_address == $past(program_page_register))
      else $error("upper address not page");
   AST_IDLE_SEL: assert property (@(posedge clock) disable iff (!reset_n)
      !bus.valid |=> sel_reg == '0)
      else $error("select without bus cycle");
   AST_ECS_OFF: assert property (@(posedge clock) disable iff (!reset_n)
      !port_k_emulation_enable |=> emulation_chip_select_n
      && external_chip_select_n)
      else $error("chip select without port K emulation");
   AST_WIN_EXT: assert property (@(posedge clock) disable iff (!reset_n)
      bus.valid && in_win && !page_int |=> !sel_reg.prog)
      else $error("external page selected program memory");
   AST_TOP_UNPAGED: assert property (@(posedge clock) disable iff (!reset_n)
      expanded && port_k_emulation_enable && a >= `ADPW_WIN_LO && !in_win
      |=> extended_upper_address == `ADPW_XA_TOP)
      else $error("top block paged");
endmodule // adpw_decode

// File: adpw_defs.svh
// Purpose: Constants for the address decode and page window block
// Assumes: 16-bit core address bus, six-bit page index
// Notes: Offsets are relative to the register block base
//
// Contract
// - Only one select is active at any time.
// - Priority: debug, registers, RAM, EEPROM, program memory, external.
// - Expanded modes: unclaimed space and ports A/B registers go external.
// - Port E emulation bit in expanded modes sends port E registers external.
// - Special peripheral mode drops the first 16 expansion registers.
// - Emulation with port K emulation bit sends port K registers external.
// - Port K bit 7 is low-active emulation select for program space.
// - Port K bit 6 is low-active external select when emulation select idle.
// - External select stays idle for unimplemented or removed register slots.
// - Selects depend on operating mode and mapping control settings.
// - Six-bit page picks a 16K block shown at 0x8000 to 0xBFFF.
// - Partition switches set which pages are internal; lower pages external.
// - Region 0xC000 to 0xFFFF is never paged.
// - Page register has 64 pages, bus and sequence readable and writable; the code has no bus read path for it.
// - Bus page writes take effect one cycle later; sequence writes in time.
// - Port K emulation in expanded mode drives page onto upper address.
`ifndef ADPW_DEFS_SVH
`define ADPW_DEFS_SVH
`define ADPW_WIN_LO 16'h8000
`define ADPW_WIN_HI 16'hBFFF
`define ADPW_REG_SIZE 16'h0400
`define ADPW_DBG_SIZE 16'h0100
`define ADPW_EXP_REGS 16'h0010
`define ADPW_PORTA_OFS 16'h0000
`define ADPW_PORTB_OFS 16'h0001
`define ADPW_DDRA_OFS 16'h0002
`define ADPW_DDRB_OFS 16'h0003
`define ADPW_PORTE_OFS 16'h0008
`define ADPW_DDRE_OFS 16'h0009
`define ADPW_PORTK_OFS 16'h0032
`define ADPW_DDRK_OFS 16'h0033
`define ADPW_PAGE_OFS 16'h0030
`define ADPW_PAGE_RESET 6'h00
`define ADPW_PART_128K 6'h38
`define ADPW_PART_256K 6'h30
`define ADPW_PART_512K 6'h20
`define ADPW_XA_LOW 6'h3D
`define ADPW_XA_MID 6'h3E
`define ADPW_XA_TOP 6'h3F
`endif

// File: adpw_pkg.sv
// Purpose: Types for the address decode and page window block
// Assumes: Included constants header
// Notes: Mode encoding is local to this block
package adpw_pkg;
   typedef enum logic [2:0]
   {
      ADPW_MODE_SINGLE = 3'h0,
      ADPW_MODE_SPECIAL_SINGLE = 3'h1,
      ADPW_MODE_NORMAL_EXP = 3'h2,
      ADPW_MODE_EMUL_EXP = 3'h3,
      ADPW_MODE_TEST = 3'h4,
      ADPW_MODE_PERIPH = 3'h5
   } adpw_mode_t;

   typedef struct packed
   {
      logic debug;
      logic regs;
      logic ram;
      logic eeprom;
      logic prog;
      logic ext;
   } adpw_sel_t;

   typedef struct packed
   {
      logic [15:0] addr;
      logic valid;
      logic write;
      logic [7:0] wdata;
   } adpw_bus_t;

   typedef struct packed
   {
      logic debug_en;
      logic [15:0] reg_base;
      logic [15:0] ram_base;
      logic [15:0] ram_size;
      logic [15:0] ee_base;
      logic [15:0] ee_size;
      logic prog_low_en;
      logic [15:0] prog_low_base;
   } adpw_map_t;
endpackage

// File: adpw_page_class.sv
// Purpose: Classify a page index as internal or external
// Assumes: Partition switches are static integration settings
// Notes: Pure combinational helper
`timescale 1ns/10ps
`include "adpw_defs.svh"
module adpw_page_class
   import adpw_pkg::*;
(
   // Page and switches
   input wire logic [5:0] page_index_bits,
   input wire logic [1:0] paging_partition_switches,
   // Result
   output logic internal
);
   always_comb
   begin
      case (paging_partition_switches)
         2'b00: internal = (page_index_bits >= `ADPW_PART_128K);
         2'b01: internal = (page_index_bits >= `ADPW_PART_256K);
         2'b10: internal = (page_index_bits >= `ADPW_PART_512K);
         default: internal = 1'b1;
      endcase
   end
endmodule // adpw_page_class

// File: adpw_core_model.sv
// Purpose: Core model issuing far call and far return page loads
// Assumes: One page load per sequence, one clock after the request
// Notes: Return address traffic is not modelled, only the page stack
`timescale 1ns/10ps
module adpw_core_model
   import adpw_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Sequence requests
   input wire logic call_req,
   input wire logic rtc_req,
   input wire logic [5:0] call_page,
   input wire logic [5:0] cur_page,
   // Page load to the decoder
   output logic seq_page_load,
   output logic [5:0] seq_page_value
);
   logic [5:0] stack_reg [0:7];
   logic [2:0] sp_reg;
   logic [5:0] temp_reg;
   // A running sequence refuses new requests, so none is split
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sp_reg <= 3'h0;
         temp_reg <= 6'h00;
         seq_page_load <= 1'b0;
         seq_page_value <= 6'h00;
      end
      else
      begin
         seq_page_load <= 1'b0;
         if (call_req && !seq_page_load)
         begin
            temp_reg <= cur_page;
            stack_reg[sp_reg] <= cur_page;
            sp_reg <= sp_reg + 3'h1;
            seq_page_load <= 1'b1;
            seq_page_value <= call_page;
         end
         else if (rtc_req && !seq_page_load)
         begin
            sp_reg <= sp_reg - 3'h1;
            seq_page_load <= 1'b1;
            seq_page_value <= stack_reg[sp_reg - 3'h1];
         end
      end
   end
endmodule // adpw_core_model

// File: adpw_decode_test.sv
// Purpose: Self-checking bench for the address decode block
// Assumes: Outputs registered one cycle after the bus edge
// Notes: Corner pages first, then pages and window offsets drawn from a fixed seed
`timescale 1ns/10ps
`include "adpw_defs.svh"
module adpw_decode_test
   import adpw_pkg::*;
;
   logic clock, reset_n, seq_load, pe_emu, pk_emu, call_req, rtc_req;
   logic emu_n, ext_n, pint, ok;
   adpw_bus_t bus;
   adpw_mode_t mode;
   adpw_map_t map;
   adpw_sel_t sel;
   logic [5:0] seq_val, call_page, xa, page, p;
   logic [1:0] pp, ra;
   logic [7:0] w;
   logic [15:0] a;
   logic [5:0] corner [0:7] = '{6'h00, 6'h1F, 6'h20, 6'h2F,
      6'h30, 6'h37, 6'h38, 6'h3F};
   int failures, cmp_count, seed, i;

   adpw_decode uut (.clock(clock), .reset_n(reset_n), .bus(bus),
      .seq_page_load(seq_load), .seq_page_value(seq_val), .mode(mode),
      .map(map), .port_e_emulation_enable(pe_emu),
      .port_k_emulation_enable(pk_emu), .prog_low_hide(1'b1),
      .rom_alloc_switches(ra), .paging_partition_switches(pp),
      .sel_reg(sel), .emulation_chip_select_n(emu_n),
      .external_chip_select_n(ext_n), .extended_upper_address(xa),
      .program_page_register(page), .page_internal_reg(pint));
   adpw_core_model core (.clock(clock), .reset_n(reset_n),
      .call_req(call_req), .rtc_req(rtc_req), .call_page(call_page),
      .cur_page(page), .seq_page_load(seq_load), .seq_page_value(seq_val));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task give_verdict;
      $display("failures=%0d cmp_count=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task chk_sel(input adpw_sel_t g, input adpw_sel_t e);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("FAIL t=%0t sel=%h exp=%h", $time, g, e);
      end
   endtask

   task access(input logic [15:0] ad, input logic wr, input logic [7:0] d);
      @(posedge clock);
      bus <= '{ad, 1'b1, wr, d};
      @(posedge clock);
      bus.valid <= 1'b0;
      #1;
   endtask

   task dec(input logic [15:0] ad, input adpw_mode_t m,
      input logic [5:0] es, input logic ex);
      mode <= m;
      access(ad, 1'b0, 8'h00);
      chk_sel(sel, adpw_sel_t'(es));
      chk(ext_n, ex);
   endtask

   task far(input logic c, input logic [5:0] np, input logic [5:0] e);
      @(posedge clock);
      call_req <= c;
      rtc_req <= !c;
      call_page <= np;
      @(posedge clock);
      call_req <= 1'b0;
      rtc_req <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk(page, e);
   endtask

   function logic inside_exp(input logic [1:0] s, input logic [5:0] q);
      return s == 2'h3 || (s == 2'h2 && q >= 6'h20) ||
         (s == 2'h1 && q >= 6'h30) || q >= 6'h38;
   endfunction

   initial
   begin
      #100000;
      failures++;
      give_verdict;
   end

   initial
   begin
      seed = 61;
      failures = 0;
      cmp_count = 0;
      reset_n = 1'b0;
      bus = '0;
      mode = ADPW_MODE_EMUL_EXP;
      map = '{1'b0, 16'h0000, 16'h0000, 16'h1000, 16'h0C00, 16'h0800,
         1'b0, 16'h0000};
      {pe_emu, pk_emu, call_req, rtc_req, call_page, pp} = '0;
      pk_emu = 1'b1;
      ra = 2'h3;
      repeat (12) @(posedge clock);
      #1;
      chk_sel(sel, 6'h00);
      chk({emu_n, ext_n}, 8'h03);
      chk(xa, 6'h3F);
      chk({pint, page}, 8'h00);
      reset_n <= 1'b1;
      for (i = 0; i < 48; i++)
      begin
         w = 8'($random(seed));
         if (i < 32)
            w = {2'h3, corner[i[4:2]]};
         p = w[5:0];
         pp <= i[1:0];
         access(`ADPW_PAGE_OFS, 1'b1, w);
         chk(page, p);
         @(posedge clock);
         #1;
         ok = inside_exp(i[1:0], p);
         chk(pint, ok);
         a = {2'b10, 14'($random(seed))};
         access(a, 1'b0, 8'h00);
         chk_sel(sel, ok ? 6'h02 : 6'h01);
         chk({emu_n, ext_n}, {!ok, ok});
         chk(xa, p);
      end
      far(1'b1, 6'h15, 6'h15);
      far(1'b1, 6'h2A, 6'h2A);
      far(1'b0, 6'h00, 6'h15);
      far(1'b0, 6'h00, p);
      dec(16'h0100, ADPW_MODE_EMUL_EXP, 6'h10, 1'b1);
      dec(16'h0D00, ADPW_MODE_EMUL_EXP, 6'h08, 1'b1);
      dec(16'h1200, ADPW_MODE_EMUL_EXP, 6'h04, 1'b1);
      dec(16'h1800, ADPW_MODE_EMUL_EXP, 6'h01, 1'b0);
      chk(xa, 6'h3D);
      dec(16'h5000, ADPW_MODE_EMUL_EXP, 6'h01, 1'b0);
      chk(xa, 6'h3E);
      dec(16'hC000, ADPW_MODE_EMUL_EXP, 6'h02, 1'b1);
      chk({emu_n, xa}, 8'h3F);
      ra <= 2'h0;
      dec(16'hC000, ADPW_MODE_EMUL_EXP, 6'h01, 1'b0);
      chk({emu_n, xa}, 8'h7F);
      ra <= 2'h3;
      dec(16'h0000, ADPW_MODE_NORMAL_EXP, 6'h01, 1'b1);
      dec(16'h0002, ADPW_MODE_TEST, 6'h01, 1'b1);
      dec(16'h0000, ADPW_MODE_SPECIAL_SINGLE, 6'h10, 1'b1);
      dec(16'h0001, ADPW_MODE_SINGLE, 6'h10, 1'b1);
      dec(16'h0032, ADPW_MODE_NORMAL_EXP, 6'h10, 1'b1);
      dec(16'h0032, ADPW_MODE_EMUL_EXP, 6'h01, 1'b1);
      dec(16'h0009, ADPW_MODE_NORMAL_EXP, 6'h10, 1'b1);
      pe_emu <= 1'b1;
      dec(16'h0009, ADPW_MODE_NORMAL_EXP, 6'h01, 1'b1);
      mode <= ADPW_MODE_PERIPH;
      access(16'h000C, 1'b0, 8'h00);
      chk(sel.regs, 1'b0);
      dec(16'h0010, ADPW_MODE_PERIPH, 6'h10, 1'b1);
      pk_emu <= 1'b0;
      dec(16'h1800, ADPW_MODE_EMUL_EXP, 6'h01, 1'b1);
      dec(16'h0032, ADPW_MODE_EMUL_EXP, 6'h10, 1'b1);
      dec(16'hC000, ADPW_MODE_EMUL_EXP, 6'h02, 1'b1);
      chk(emu_n, 1'b1);
      pk_emu <= 1'b1;
      map.debug_en <= 1'b1;
      dec(16'hFF80, ADPW_MODE_EMUL_EXP, 6'h20, 1'b1);
      @(posedge clock);
      #1;
      chk_sel(sel, 6'h00);
      give_verdict;
   end
endmodule // adpw_decode_test
